/* File: src/tmr_cc_pkg.sv */
// Package: register map, field positions and carriers for the timer block
// Functional notes
// - Compare registers checked against counter every tick
// - Compare match raises flag and drives output pin
// - Compare writes use shared high byte latch
// - Capture event copies counter into capture register
// - First timer capture source: pin or comparator
// - Capture register may serve as counter top
// - Low byte read latches capture high byte
// - Request needs mask, global enable and flag
// - First timer capture enable at shared mask bit5
// - First timer compare A/B enables bits 4/3
// - First timer overflow enable at shared bit 2
// - Second timer capture enable at extended bit5
// - Second timer compare A/B enables bits 4/3
// - Second timer overflow bit2, compare C bit1
// - Extended mask absent in legacy mode
// - First timer compare C enable extended bit0
// - Flags clear on vector, written one or a read of the flag register
package tmr_cc_pkg;

    localparam logic [7:0] OFS_SH_MASK = 8'h00;
    localparam logic [7:0] OFS_SH_FLAG = 8'h04;
    localparam logic [7:0] OFS_EX_MASK = 8'h08;
    localparam logic [7:0] OFS_EX_FLAG = 8'h0C;
    localparam logic [7:0] OFS_CTRL = 8'h10;
    // Wide registers at 0x40 + 8*index, low byte +0, high byte +4
    localparam logic [1:0] WIDE_REGION = 2'b01;

    localparam int W_T1_A = 0;
    localparam int W_T1_B = 1;
    localparam int W_T1_C = 2;
    localparam int W_T3_A = 3;
    localparam int W_T3_B = 4;
    localparam int W_T3_C = 5;
    localparam int W_T1_CAP = 6;
    localparam int W_T3_CAP = 7;

    localparam int BIT_CAPT = 5;
    localparam int BIT_CMP_A = 4;
    localparam int BIT_CMP_B = 3;
    localparam int BIT_OVF = 2;
    localparam int BIT_T3_CMP_C = 1;
    localparam int BIT_T1_CMP_C = 0;

    localparam int CTRL_T1_ACMP = 0;
    localparam int CTRL_T1_RISE = 1;
    localparam int CTRL_T3_RISE = 2;

    localparam logic [7:0] SH_FLAG_IMPL = 8'h3C;
    localparam logic [7:0] EX_IMPL = 8'h3F;
    localparam logic [7:0] RST_MASK = 8'h00;
    localparam logic [7:0] RST_FLAG = 8'h00;
    localparam logic [2:0] RST_CTRL = 3'h0;
    localparam logic [15:0] RST_WIDE = 16'h0000;

    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_DECERR = 2'b11;

    typedef struct packed {
        logic [7:0] ext;
        logic [7:0] shared;
    } irq_set_s;

endpackage

/* File: src/timer_cc_irq.sv */
// Compare/capture registers and interrupt flags of two 16-bit timers
module timer_cc_irq (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write address
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // AXI4-Lite write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read address
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // AXI4-Lite read data
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Counter side, same clock
    input wire logic [15:0] counter_value_t1,
    input wire logic [15:0] counter_value_t3,
    input wire logic [1:0] timer_tick,
    input wire logic [1:0] overflow_evt,
    input wire logic [1:0] capture_as_top,
    // CPU side, same clock
    input wire logic global_irq_en,
    input wire logic legacy_mode,
    input wire tmr_cc_pkg::irq_set_s vector_ack,
    // Asynchronous pins
    input wire logic [1:0] capture_input_pin,
    input wire logic analog_cmp_out,
    // Results
    output logic [5:0] compare_output_pin,
    output logic [15:0] first_timer_capture_value,
    output logic [15:0] second_timer_capture_value,
    output tmr_cc_pkg::irq_set_s irq_req,
    output logic irq
);

    function automatic logic is_wide(input logic [7:0] a);
        is_wide = (a[7:6] == tmr_cc_pkg::WIDE_REGION) && (a[1:0] == 2'b00);
    endfunction

    function automatic logic [7:0] impl_w1c(input logic [7:0] flags,
                                             input logic [7:0] impl);
        impl_w1c = flags & impl;
    endfunction

    logic [15:0] wide_r [0:7];
    logic [7:0] temp_r;
    logic [7:0] sh_mask_r;
    logic [7:0] ex_mask_r;
    logic [7:0] sh_flag_r;
    logic [7:0] ex_flag_r;
    logic [7:0] sh_flag_nxt;
    logic [7:0] ex_flag_nxt;
    logic [2:0] ctrl_r;
    logic [5:0] match_r;
    logic [5:0] cmp_pin_r;
    logic [2:0] pin_s1_r;
    logic [2:0] pin_s2_r;
    logic [2:0] pin_s3_r;

    logic aw_held_r;
    logic w_held_r;
    logic [7:0] aw_addr_r;
    logic [7:0] w_data_r;
    logic w_strb0_r;
    logic bvalid_r;
    logic [1:0] bresp_r;
    logic rvalid_r;
    logic [31:0] rdata_r;
    logic [1:0] rresp_r;

    // Write channel decode
    wire wr_go = aw_held_r & w_held_r & ~bvalid_r;
    wire wr_en = wr_go & w_strb0_r;
    wire wr_wide = is_wide(aw_addr_r);
    wire [2:0] wr_idx = aw_addr_r[5:3];
    wire wr_hi = aw_addr_r[2];
    wire wr_sh_mask = aw_addr_r == tmr_cc_pkg::OFS_SH_MASK;
    wire wr_sh_flag = aw_addr_r == tmr_cc_pkg::OFS_SH_FLAG;
    wire wr_ex_mask = aw_addr_r == tmr_cc_pkg::OFS_EX_MASK;
    wire wr_ex_flag = aw_addr_r == tmr_cc_pkg::OFS_EX_FLAG;
    wire wr_ctrl = aw_addr_r == tmr_cc_pkg::OFS_CTRL;
    wire wr_hit = wr_wide | wr_sh_mask | wr_sh_flag | wr_ex_mask
        | wr_ex_flag | wr_ctrl;

    // Read channel decode
    wire rd_go = s_axi_arvalid & ~rvalid_r;
    wire [7:0] ra = s_axi_araddr;
    wire rd_wide = is_wide(ra);
    wire [2:0] rd_idx = ra[5:3];
    wire rd_hi = ra[2];
    wire rd_sh_mask = ra == tmr_cc_pkg::OFS_SH_MASK;
    wire rd_sh_flag = ra == tmr_cc_pkg::OFS_SH_FLAG;
    wire rd_ex_mask = ra == tmr_cc_pkg::OFS_EX_MASK;
    wire rd_ex_flag = ra == tmr_cc_pkg::OFS_EX_FLAG;
    wire rd_ctrl = ra == tmr_cc_pkg::OFS_CTRL;
    wire rd_hit = rd_wide | rd_sh_mask | rd_sh_flag | rd_ex_mask
        | rd_ex_flag | rd_ctrl;

    // Extended mask vanishes in legacy mode
    wire [7:0] ex_mask_eff = legacy_mode ? 8'h00 : ex_mask_r;

    wire [7:0] rd_byte =
        rd_wide ? (rd_hi ? temp_r : wide_r[rd_idx][7:0]) :
        rd_sh_mask ? sh_mask_r :
        rd_sh_flag ? impl_w1c(sh_flag_r, tmr_cc_pkg::SH_FLAG_IMPL) :
        rd_ex_mask ? ex_mask_eff :
        rd_ex_flag ? impl_w1c(ex_flag_r, tmr_cc_pkg::EX_IMPL) :
        rd_ctrl ? {5'h00, ctrl_r} : 8'h00;

    // Compare against running counter on each timer tick
    wire [5:0] match_w;
    assign match_w[0] = timer_tick[0]
        & (counter_value_t1 == wide_r[tmr_cc_pkg::W_T1_A]);
    assign match_w[1] = timer_tick[0]
        & (counter_value_t1 == wide_r[tmr_cc_pkg::W_T1_B]);
    assign match_w[2] = timer_tick[0]
        & (counter_value_t1 == wide_r[tmr_cc_pkg::W_T1_C]);
    assign match_w[3] = timer_tick[1]
        & (counter_value_t3 == wide_r[tmr_cc_pkg::W_T3_A]);
    assign match_w[4] = timer_tick[1]
        & (counter_value_t3 == wide_r[tmr_cc_pkg::W_T3_B]);
    assign match_w[5] = timer_tick[1]
        & (counter_value_t3 == wide_r[tmr_cc_pkg::W_T3_C]);

    // Capture edges; index 0 first pin, 1 second pin, 2 comparator
    wire [2:0] rise_w = pin_s2_r & ~pin_s3_r;
    wire [2:0] fall_w = ~pin_s2_r & pin_s3_r;
    wire t1_src_rise = ctrl_r[tmr_cc_pkg::CTRL_T1_ACMP] ?
        rise_w[2] : rise_w[0];
    wire t1_src_fall = ctrl_r[tmr_cc_pkg::CTRL_T1_ACMP] ?
        fall_w[2] : fall_w[0];
    wire t1_edge = ctrl_r[tmr_cc_pkg::CTRL_T1_RISE] ?
        t1_src_rise : t1_src_fall;
    wire t3_edge = ctrl_r[tmr_cc_pkg::CTRL_T3_RISE] ?
        rise_w[1] : fall_w[1];
    // Top mode disconnects the pin, so no capture can corrupt the top
    wire cap1 = t1_edge & ~capture_as_top[0];
    wire cap3 = t3_edge & ~capture_as_top[1];
    wire top1 = capture_as_top[0] & timer_tick[0]
        & (counter_value_t1 == wide_r[tmr_cc_pkg::W_T1_CAP]);
    wire top3 = capture_as_top[1] & timer_tick[1]
        & (counter_value_t3 == wide_r[tmr_cc_pkg::W_T3_CAP]);

    // Flag sources
    wire [7:0] sh_set = {2'b00, cap1 | top1, match_r[0], match_r[1],
        overflow_evt[0], 2'b00};
    wire [7:0] ex_set = {2'b00, cap3 | top3, match_r[3], match_r[4],
        overflow_evt[1], match_r[5], match_r[2]};
    wire rd_clr_sh = rd_go & rd_sh_flag;
    wire rd_clr_ex = rd_go & rd_ex_flag;
    wire [7:0] sh_clr = vector_ack.shared
        | ((wr_en & wr_sh_flag) ? w_data_r : 8'h00)
        | (rd_clr_sh ? 8'hFF : 8'h00);
    wire [7:0] ex_clr = vector_ack.ext
        | ((wr_en & wr_ex_flag) ? w_data_r : 8'h00)
        | (rd_clr_ex ? 8'hFF : 8'h00);

    // A set in the clearing cycle is kept
    assign sh_flag_nxt = ((sh_flag_r & ~sh_clr) | sh_set)
        & tmr_cc_pkg::SH_FLAG_IMPL;
    assign ex_flag_nxt = ((ex_flag_r & ~ex_clr) | ex_set)
        & tmr_cc_pkg::EX_IMPL;

    // Interrupt gating: flag, mask and global enable
    assign irq_req.shared = global_irq_en ?
        (sh_flag_r & sh_mask_r & tmr_cc_pkg::SH_FLAG_IMPL) : 8'h00;
    assign irq_req.ext = global_irq_en ?
        (ex_flag_r & ex_mask_eff & tmr_cc_pkg::EX_IMPL) : 8'h00;
    assign irq = |irq_req;

    assign compare_output_pin = cmp_pin_r;
    assign first_timer_capture_value = wide_r[tmr_cc_pkg::W_T1_CAP];
    assign second_timer_capture_value = wide_r[tmr_cc_pkg::W_T3_CAP];

    assign s_axi_awready = ~aw_held_r & ~bvalid_r;
    assign s_axi_wready = ~w_held_r & ~bvalid_r;
    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp = bresp_r;
    assign s_axi_arready = ~rvalid_r;
    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rdata = rdata_r;
    assign s_axi_rresp = rresp_r;

    // Pin synchronisers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pin_s1_r <= 3'h0;
            pin_s2_r <= 3'h0;
            pin_s3_r <= 3'h0;
        end else begin
            pin_s1_r <= {analog_cmp_out, capture_input_pin};
            pin_s2_r <= pin_s1_r;
            pin_s3_r <= pin_s2_r;
        end
    end

    // Flag rises two cycles after the match tick
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            match_r <= 6'h00;
            cmp_pin_r <= 6'h00;
        end else begin
            match_r <= match_w;
            cmp_pin_r <= cmp_pin_r ^ match_r;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sh_flag_r <= tmr_cc_pkg::RST_FLAG;
            ex_flag_r <= tmr_cc_pkg::RST_FLAG;
        end else begin
            sh_flag_r <= sh_flag_nxt;
            ex_flag_r <= ex_flag_nxt;
        end
    end

    // Mask and control registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sh_mask_r <= tmr_cc_pkg::RST_MASK;
            ex_mask_r <= tmr_cc_pkg::RST_MASK;
            ctrl_r <= tmr_cc_pkg::RST_CTRL;
        end else begin
            if (wr_en && wr_sh_mask) begin
                sh_mask_r <= w_data_r;
            end
            if (wr_en && wr_ex_mask && !legacy_mode) begin
                ex_mask_r <= w_data_r & tmr_cc_pkg::EX_IMPL;
            end
            if (wr_en && wr_ctrl) begin
                ctrl_r <= w_data_r[2:0];
            end
        end
    end

    // Shared high byte latch; a write wins over a read's latch
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            temp_r <= 8'h00;
        end else if (wr_en && wr_wide && wr_hi) begin
            temp_r <= w_data_r;
        end else if (rd_go && rd_wide && !rd_hi) begin
            temp_r <= wide_r[rd_idx][15:8];
        end
    end

    // Sixteen-bit registers; capture beats a same-cycle write
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            for (int i = 0; i < 8; i++) begin
                wide_r[i] <= tmr_cc_pkg::RST_WIDE;
            end
        end else begin
            if (wr_en && wr_wide && !wr_hi) begin
                wide_r[wr_idx] <= {temp_r, w_data_r};
            end
            if (cap1) begin
                wide_r[tmr_cc_pkg::W_T1_CAP] <= counter_value_t1;
            end
            if (cap3) begin
                wide_r[tmr_cc_pkg::W_T3_CAP] <= counter_value_t3;
            end
        end
    end

    // AXI write side: address and data taken in either order
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_r <= 1'b0;
            w_held_r <= 1'b0;
            aw_addr_r <= 8'h00;
            w_data_r <= 8'h00;
            w_strb0_r <= 1'b0;
            bvalid_r <= 1'b0;
            bresp_r <= tmr_cc_pkg::RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held_r <= 1'b1;
                aw_addr_r <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held_r <= 1'b1;
                w_data_r <= s_axi_wdata[7:0];
                w_strb0_r <= s_axi_wstrb[0];
            end
            if (wr_go) begin
                aw_held_r <= 1'b0;
                w_held_r <= 1'b0;
                bvalid_r <= 1'b1;
                bresp_r <= wr_hit ? tmr_cc_pkg::RESP_OKAY
                    : tmr_cc_pkg::RESP_DECERR;
            end else if (bvalid_r && s_axi_bready) begin
                bvalid_r <= 1'b0;
            end
        end
    end

    // AXI read side: data one edge after the address is taken
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_r <= 1'b0;
            rdata_r <= 32'h0000_0000;
            rresp_r <= tmr_cc_pkg::RESP_OKAY;
        end else if (rd_go) begin
            rvalid_r <= 1'b1;
            rdata_r <= {24'h00_0000, rd_byte};
            rresp_r <= rd_hit ? tmr_cc_pkg::RESP_OKAY
                : tmr_cc_pkg::RESP_DECERR;
        end else if (rvalid_r && s_axi_rready) begin
            rvalid_r <= 1'b0;
        end
    end

endmodule

/* File: tb/timer_cc_irq_chk.sv */
// Checker: bus answers and interrupt relations of the timer block
module timer_cc_irq_chk (
    // Clock and reset
    input logic aclk,
    input logic aresetn,
    // Register bus
    input logic s_axi_awvalid,
    input logic s_axi_awready,
    input logic s_axi_wvalid,
    input logic s_axi_wready,
    input logic [1:0] s_axi_bresp,
    input logic s_axi_bvalid,
    input logic s_axi_bready,
    input logic s_axi_arvalid,
    input logic s_axi_arready,
    input logic [31:0] s_axi_rdata,
    input logic s_axi_rvalid,
    input logic s_axi_rready,
    // Timer and interrupt side
    input logic [1:0] timer_tick,
    input logic [1:0] overflow_evt,
    input logic global_irq_en,
    input logic legacy_mode,
    input logic [5:0] compare_output_pin,
    input tmr_cc_pkg::irq_set_s irq_req,
    input logic irq
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    sequence s_wr_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence s_rd_taken;
        s_axi_arvalid && s_axi_arready;
    endsequence

    AST_WR_ANSWER: assert property (
        s_wr_taken |-> ##2 s_axi_bvalid)
        else $error("write answer not two cycles after handshake");
    AST_RD_ANSWER: assert property (
        s_rd_taken |=> s_axi_rvalid)
        else $error("read answer not one cycle after handshake");
    // An answer stands until taken and is gone right after
    AST_B_STANDS: assert property (s_axi_bvalid |=>
        ($past(s_axi_bready) ? !s_axi_bvalid
            : (s_axi_bvalid && $stable(s_axi_bresp))))
        else $error("write answer not held until taken");
    AST_R_STANDS: assert property (s_axi_rvalid |=>
        ($past(s_axi_rready) ? !s_axi_rvalid
            : (s_axi_rvalid && $stable(s_axi_rdata))))
        else $error("read answer not held until taken");
    AST_IRQ_OR: assert property (irq == (|irq_req))
        else $error("irq differs from the requests");
    AST_IRQ_GLOBAL: assert property (!global_irq_en |-> !irq)
        else $error("interrupt without global enable");
    AST_LEGACY_EXT: assert property (
        legacy_mode |-> irq_req.ext == 8'h00)
        else $error("extended request while its mask is absent");
    AST_UNIMPL: assert property (
        (irq_req & 16'hc0c3) == 16'h0000)
        else $error("request on an unimplemented bit");
    AST_PIN_T1: assert property (
        $changed(compare_output_pin[2:0])
        |-> $past(timer_tick[0]) || $past(timer_tick[0], 2))
        else $error("first timer pin moved without a tick");
    AST_PIN_T3: assert property (
        $changed(compare_output_pin[5:3])
        |-> $past(timer_tick[1]) || $past(timer_tick[1], 2))
        else $error("second timer pin moved without a tick");
    // A mask write or a global enable can also raise the request
    AST_OVF_CAUSE: assert property ($rose(irq_req.shared[2])
        |-> $past(overflow_evt[0]) || $rose(global_irq_en)
            || $past(s_axi_wvalid, 2))
        else $error("overflow request without a cause");
endmodule

/* File: tb/timer_cc_irq_bench.sv */
// Bench: registers, events and interrupts of the timer block
module timer_cc_irq_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0;
    logic s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
    logic global_irq_en = 0, legacy_mode = 0, analog_cmp_out = 0;
    logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0;
    logic [31:0] s_axi_wdata = '0;
    logic [3:0] s_axi_wstrb = 4'h1;
    logic [15:0] counter_value_t1 = '0, counter_value_t3 = '0;
    logic [1:0] timer_tick = '0, overflow_evt = '0, capture_as_top = '0;
    logic [1:0] capture_input_pin = '0;
    tmr_cc_pkg::irq_set_s vector_ack = '0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid, irq;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata;
    logic [5:0] compare_output_pin;
    logic [15:0] first_timer_capture_value, second_timer_capture_value;
    tmr_cc_pkg::irq_set_s irq_req;
    logic [33:0] q[$];
    logic [15:0] cmp_v[6];
    logic [15:0] ev_bits[8] = '{16'h0010, 16'h0008, 16'h0100, 16'h1000,
        16'h0800, 16'h0200, 16'h0004, 16'h0400};
    logic [5:0] pins_exp = '0;
    int failures = 0, checks_done = 0, cycles = 0;

    timer_cc_irq u_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .counter_value_t1,
        .counter_value_t3, .timer_tick, .overflow_evt, .capture_as_top,
        .global_irq_en, .legacy_mode, .vector_ack, .capture_input_pin,
        .analog_cmp_out, .compare_output_pin, .first_timer_capture_value,
        .second_timer_capture_value, .irq_req, .irq);

    always #5 aclk = ~aclk;

    task automatic results();
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    always @(posedge aclk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            failures++;
            results();
        end
    end

    task automatic chk(input string n, input logic [33:0] e, g);
        checks_done++;
        if (g !== e) begin
            failures++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask

    // Bus answers are matched in order against the driver's notes
    always @(posedge aclk) begin
        if (s_axi_rvalid && s_axi_rready)
            chk("read", q.pop_front(), {s_axi_rresp, s_axi_rdata});
        if (s_axi_bvalid && s_axi_bready)
            chk("write", q.pop_front(), {s_axi_bresp, 32'h0});
    end

    function automatic logic [33:0] okd(input logic [7:0] d);
        return {tmr_cc_pkg::RESP_OKAY, 24'h0, d};
    endfunction

    // Response ready rises with the request and drops once answered
    task automatic wr(input logic [7:0] a, d,
        input logic [1:0] r = tmr_cc_pkg::RESP_OKAY);
        logic aw_done, w_done;
        @(posedge aclk);
        q.push_back({r, 32'h0});
        aw_done = 0;
        w_done = 0;
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h0, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!(aw_done && w_done)) begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready) begin
                aw_done = 1;
                s_axi_awvalid <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_done = 1;
                s_axi_wvalid <= 1'b0;
            end
        end
        do @(posedge aclk); while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [33:0] e);
        @(posedge aclk);
        q.push_back(e);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(posedge aclk); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        do @(posedge aclk); while (!s_axi_rvalid);
        s_axi_rready <= 1'b0;
    endtask

    task automatic rd16(input int i, input logic [15:0] v);
        rd(8'h40 + 8'(8 * i), okd(v[7:0]));
        rd(8'h44 + 8'(8 * i), okd(v[15:8]));
    endtask

    task automatic fire(input int e);
        logic [15:0] b;
        b = ev_bits[e];
        if (e < 3) counter_value_t1 <= cmp_v[e];
        else if (e < 6) counter_value_t3 <= cmp_v[e];
        if (e < 6) timer_tick[e / 3] <= 1'b1;
        else overflow_evt[e - 6] <= 1'b1;
        @(posedge aclk);
        timer_tick <= '0;
        overflow_evt <= '0;
        repeat (4) @(posedge aclk);
        if (e < 6) pins_exp[e] = ~pins_exp[e];
        chk("request", {18'h0, b}, {18'h0, irq_req});
        chk("pins", 34'(pins_exp), 34'(compare_output_pin));
        chk("irq", 34'h1, {33'h0, irq});
        global_irq_en <= 1'b0;
        repeat (2) @(posedge aclk);
        chk("gated irq", 34'h0, {33'h0, irq});
        global_irq_en <= 1'b1;
        case (e % 3)
            0: begin
                vector_ack <= b;
                @(posedge aclk);
                vector_ack <= '0;
            end
            1: rd(b[7:0] ? 8'h04 : 8'h0c, okd(b[7:0] | b[15:8]));
            default: wr(b[7:0] ? 8'h04 : 8'h0c, b[7:0] | b[15:8]);
        endcase
        repeat (2) @(posedge aclk);
        chk("cleared", 34'h0, {18'h0, irq_req});
    endtask

    initial begin
        logic [15:0] c1, c3;
        void'($urandom(32'h3be3));
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        for (int a = 0; a < 128; a += 4)
            rd(8'(a), (a < 20 || a >= 64) ? okd(8'h00)
                : {tmr_cc_pkg::RESP_DECERR, 32'h0});
        rd(8'h41, {tmr_cc_pkg::RESP_DECERR, 32'h0});
        wr(8'h20, 8'h55, tmr_cc_pkg::RESP_DECERR);
        c1 = 16'($urandom);
        wr(8'h00, c1[7:0]);
        rd(8'h00, okd(c1[7:0]));
        wr(8'h08, 8'hff);
        rd(8'h08, okd(8'h3f));
        legacy_mode <= 1'b1;
        rd(8'h08, okd(8'h00));
        wr(8'h08, 8'h00);
        legacy_mode <= 1'b0;
        rd(8'h08, okd(8'h3f));
        wr(8'h00, 8'hff);
        for (int i = 0; i < 6; i++) begin
            cmp_v[i] = 16'($urandom);
            wr(8'h44 + 8'(8 * i), cmp_v[i][15:8]);
            wr(8'h40 + 8'(8 * i), cmp_v[i][7:0]);
        end
        for (int i = 0; i < 6; i++) rd16(i, cmp_v[i]);
        global_irq_en <= 1'b1;
        for (int e = 0; e < 8; e++) fire(e);
        wr(8'h10, 8'h06);
        c1 = 16'($urandom);
        c3 = 16'($urandom);
        counter_value_t1 <= c1;
        counter_value_t3 <= c3;
        capture_input_pin <= 2'b11;
        repeat (6) @(posedge aclk);
        chk("cap1", 34'(c1), 34'(first_timer_capture_value));
        chk("cap3", 34'(c3), 34'(second_timer_capture_value));
        chk("cap request", 34'h2020, 34'(irq_req));
        rd16(6, c1);
        rd16(7, c3);
        rd(8'h04, okd(8'h20));
        rd(8'h0c, okd(8'h20));
        wr(8'h10, 8'h07);
        c1 = ~c1;
        counter_value_t1 <= c1;
        counter_value_t3 <= ~c3;
        capture_input_pin <= 2'b00;
        analog_cmp_out <= 1'b1;
        capture_as_top <= 2'b10;
        repeat (6) @(posedge aclk);
        chk("cap cmp", 34'(c1), 34'(first_timer_capture_value));
        capture_input_pin <= 2'b10;
        repeat (6) @(posedge aclk);
        chk("top kept", 34'(c3), 34'(second_timer_capture_value));
        counter_value_t3 <= c3;
        timer_tick <= 2'b10;
        @(posedge aclk);
        timer_tick <= '0;
        repeat (4) @(posedge aclk);
        // The comparator capture above still holds the first timer's flag
        chk("top request", 34'h2020, 34'(irq_req));
        // Falling edge mode on the first pin: a rise must not capture
        wr(8'h10, 8'h00);
        c3 = c1;
        c1 = 16'($urandom);
        counter_value_t1 <= c1;
        capture_input_pin <= 2'b11;
        repeat (6) @(posedge aclk);
        chk("rise ignored", 34'(c3), 34'(first_timer_capture_value));
        capture_input_pin <= 2'b10;
        repeat (6) @(posedge aclk);
        chk("cap fall", 34'(c1), 34'(first_timer_capture_value));
        results();
    end
endmodule

bind timer_cc_irq timer_cc_irq_chk u_chk (.aclk, .aresetn, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .timer_tick, .overflow_evt,
    .global_irq_en, .legacy_mode, .compare_output_pin, .irq_req, .irq);
